/* File: hw/pin_change_params.svh */
// Constants for the pin-change interrupt block: register offsets,
// field positions, reset values and bus response codes.
// Assumes inclusion by bare name from the package, the design, the checker and the bench files.
`ifndef PIN_CHANGE_PARAMS_SVH
`define PIN_CHANGE_PARAMS_SVH

// ==========================================================
// Register byte offsets on the AXI4-Lite bus
`define OFS_RISE_ENABLE     12'h000
`define OFS_FALL_ENABLE     12'h004
`define OFS_CHANGE_FLAG     12'h008
`define OFS_IRQ_CONTROL     12'h00C
`define OFS_IRQ_STATUS      12'h010
`define OFS_IRQ_MASK        12'h014

// ==========================================================
// Field positions in interrupt_control_reg
`define BIT_MASTER_ENABLE   0
`define BIT_SUMMARY_FLAG    1
`define BIT_SLEEP           2

// ==========================================================
// Field positions in the sticky status and mask registers
`define BIT_EVT_EDGE        0
`define BIT_EVT_WAKE        1
`define EVT_WIDTH           2

// ==========================================================
// Reset values
`define RST_PORT_REG        8'h00
`define RST_EVT_REG         2'h0

// ==========================================================
// AXI response codes
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

/* File: hw/pin_change_pkg.sv */
// Types shared by the pin-change interrupt block.
// Assumes the params header is on the include path.
`include "pin_change_params.svh"

package pin_change_pkg;

    // ==========================================================
    // Write channel progress of the bus slave
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,   // Waiting for address and data
        WR_RESP = 2'b01    // Response held until bready
    } wr_state_t;

    // ==========================================================
    // Read channel progress of the bus slave
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,   // Waiting for an address
        RD_DATA = 2'b01    // Data held until rready
    } rd_state_t;

endpackage : pin_change_pkg

/* File: hw/pin_change_interrupt.sv */
// Pin-change interrupt source for one monitored port, with an
// AXI4-Lite register slave, sticky event status and a level interrupt.
// Assumes pins synchronous to clk, a single 40 MHz clock domain and an
// AXI4-Lite master that keeps its valid and payload stable until taken.
`timescale 1ns/1ps
`include "pin_change_params.svh"

// Behaviour
// R01: Each pin configurable for rising, falling, both
// R02: Interrupt request only with master enable set; change_irq obeys, irq is not gated by it
// R03: Master enable clear still detects and flags
// R04: Per-pin rise and fall detectors, each enabled
// R05: Rise enable bit detects low-to-high
// R06: Fall enable bit detects high-to-low
// R07: Both enables detect both transitions
// R08: Enabled edge sets that pin's flag
// R09: Summary flag is OR of flags, unstored
// R10: Writing zero clears flag, one keeps
// R11: Edge during clearing write keeps flag set
// R12: Software clears by AND of seen bits
// R13: Pin change wakes from sleep when enabled
// R14: Sleep edge recorded before wake completes
// R15: Port is eight pins, one bit each
// R16: Pins synchronised, edges from sample compare
// R17: Reset clears enables and flags
module pin_change_interrupt
    import pin_change_pkg::*;
#(
    parameter int WIDTH      = 8,    // Port width
    parameter int ADDR_WIDTH = 12    // AXI address width
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic [WIDTH-1:0]        monitored_port,
    output logic                         change_irq,
    output logic                         wake_request,
    output logic                         irq,
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    // ==========================================================
    // Declarations
    logic [WIDTH-1:0]      sync_stage1;             // First synchroniser stage
    logic [WIDTH-1:0]      sync_stage2;             // Synchronised pin level
    logic [WIDTH-1:0]      last_sample;             // Previous synchronised level
    logic [WIDTH-1:0]      rise_enable_reg;         // Per-pin rising enables
    logic [WIDTH-1:0]      fall_enable_reg;         // Per-pin falling enables
    logic [WIDTH-1:0]      change_flag_reg;         // Per-pin change flags
    logic                  change_irq_master_enable;// Master enable
    logic                  sleep_mode;              // Software sleep indication
    logic [`EVT_WIDTH-1:0] evt_status;              // Sticky event status
    logic [`EVT_WIDTH-1:0] evt_mask;                // Event mask
    logic [WIDTH-1:0]      edge_hit;                // Enabled edges this cycle
    logic [`EVT_WIDTH-1:0] evt_set;                 // Events setting the status
    logic                  change_summary_flag;     // OR of all flags
    wr_state_t             wr_state;                // Write channel state
    rd_state_t             rd_state;                // Read channel state
    logic [ADDR_WIDTH-1:0] aw_addr;                 // Captured write address
    logic                  aw_held;                 // Write address captured
    logic [31:0]           w_data;                  // Captured write data
    logic [3:0]            w_strb;                  // Captured strobes
    logic                  w_held;                  // Write data captured
    logic                  wr_fire;                 // Write takes effect
    logic                  rd_fire;                 // Read address accepted
    logic [31:0]           rd_value;                // Decoded read value
    logic                  rd_ok;                   // Read address mapped
    logic                  wr_ok;                   // Write address mapped

    // ==========================================================
    // Address match helper, used by both channels
    function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a,
                                     input logic [11:0] ofs);
        addr_is = (a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(ofs >> 2));
    endfunction : addr_is

    // Byte lane 0 merge helper; narrow registers live in the low byte
    function automatic logic [WIDTH-1:0] lane0(input logic [WIDTH-1:0] old_v,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
        lane0 = s[0] ? d[WIDTH-1:0] : old_v;
    endfunction : lane0

    // ==========================================================
    // Pin synchroniser and previous sample
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_stage1 <= '0;
            sync_stage2 <= '0;
            last_sample <= '0;
        end else begin
            sync_stage1 <= monitored_port;                  // R16
            sync_stage2 <= sync_stage1;                     // R16
            last_sample <= sync_stage2;                     // R16
        end
    end

    // Edge detectors, each gated by its own enable
    always_comb begin
        edge_hit = (rise_enable_reg & sync_stage2 & ~last_sample)     // R04 R05 R07 R01
                 | (fall_enable_reg & ~sync_stage2 & last_sample);    // R04 R06 R07 R15
    end

    // Summary flag is combinational, no storage
    assign change_summary_flag = |change_flag_reg;           // R09

    // ==========================================================
    // Bus write channel
    assign wr_fire = aw_held && w_held && (wr_state == WR_IDLE);
    assign wr_ok   = addr_is(aw_addr, `OFS_RISE_ENABLE) || addr_is(aw_addr, `OFS_FALL_ENABLE)
                   || addr_is(aw_addr, `OFS_CHANGE_FLAG) || addr_is(aw_addr, `OFS_IRQ_CONTROL)
                   || addr_is(aw_addr, `OFS_IRQ_STATUS) || addr_is(aw_addr, `OFS_IRQ_MASK);

    // Capture address and data in either order, then respond
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_addr       <= '0;
            aw_held       <= 1'b0;
            w_data        <= '0;
            w_strb        <= '0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            wr_state      <= WR_IDLE;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            case (wr_state)
                WR_IDLE: begin
                    // Address handshake
                    if (!aw_held && s_axi_awvalid && !s_axi_awready) begin
                        s_axi_awready <= 1'b1;
                    end
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_addr <= s_axi_awaddr;
                        aw_held <= 1'b1;
                    end
                    // Data handshake
                    if (!w_held && s_axi_wvalid && !s_axi_wready) begin
                        s_axi_wready <= 1'b1;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_data <= s_axi_wdata;
                        w_strb <= s_axi_wstrb;
                        w_held <= 1'b1;
                    end
                    // Both captured: commit and answer
                    if (wr_fire) begin
                        aw_held      <= 1'b0;
                        w_held       <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                        wr_state     <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    // Hold response until accepted
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state     <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state <= WR_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rise_enable_reg          <= `RST_PORT_REG;      // R17
            fall_enable_reg          <= `RST_PORT_REG;      // R17
            change_irq_master_enable <= 1'b0;
            sleep_mode               <= 1'b0;
            evt_mask                 <= `RST_EVT_REG;
        end else if (wr_fire) begin
            if (addr_is(aw_addr, `OFS_RISE_ENABLE)) begin
                rise_enable_reg <= lane0(rise_enable_reg, w_data, w_strb);
            end
            if (addr_is(aw_addr, `OFS_FALL_ENABLE)) begin
                fall_enable_reg <= lane0(fall_enable_reg, w_data, w_strb);
            end
            if (addr_is(aw_addr, `OFS_IRQ_CONTROL) && w_strb[0]) begin
                change_irq_master_enable <= w_data[`BIT_MASTER_ENABLE];
                sleep_mode               <= w_data[`BIT_SLEEP];
            end
            if (addr_is(aw_addr, `OFS_IRQ_MASK) && w_strb[0]) begin
                evt_mask <= w_data[`EVT_WIDTH-1:0];
            end
        end else if (sleep_mode && change_irq_master_enable && change_summary_flag) begin
            sleep_mode <= 1'b0;                              // R13
        end
    end

    // ==========================================================
    // Per-pin change flags: zero clears, one keeps, new edge wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            change_flag_reg <= `RST_PORT_REG;               // R17
        end else if (wr_fire && addr_is(aw_addr, `OFS_CHANGE_FLAG) && w_strb[0]) begin
            change_flag_reg <= (change_flag_reg & w_data[WIDTH-1:0]) | edge_hit; // R10 R11 R12
        end else begin
            change_flag_reg <= change_flag_reg | edge_hit;  // R08 R03 R14
        end
    end

    // ==========================================================
    // Interrupt request and wake outputs, registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            change_irq   <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            change_irq   <= change_irq_master_enable && change_summary_flag;  // R02 R03
            wake_request <= sleep_mode && change_irq_master_enable
                            && change_summary_flag;                           // R13 R14
        end
    end

    // ==========================================================
    // Sticky event status, cleared by a read; set wins over clear
    assign evt_set[`BIT_EVT_EDGE] = |edge_hit;
    assign evt_set[`BIT_EVT_WAKE] = sleep_mode && change_irq_master_enable && change_summary_flag;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_status <= `RST_EVT_REG;
            irq        <= 1'b0;
        end else begin
            if (rd_fire && addr_is(s_axi_araddr, `OFS_IRQ_STATUS)) begin
                evt_status <= evt_set;
            end else begin
                evt_status <= evt_status | evt_set;
            end
            irq <= |(evt_status & evt_mask);
        end
    end

    // ==========================================================
    // Bus read channel
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Read decode
    always_comb begin
        rd_value = '0;
        rd_ok    = 1'b1;
        if (addr_is(s_axi_araddr, `OFS_RISE_ENABLE)) begin
            rd_value[WIDTH-1:0] = rise_enable_reg;
        end else if (addr_is(s_axi_araddr, `OFS_FALL_ENABLE)) begin
            rd_value[WIDTH-1:0] = fall_enable_reg;
        end else if (addr_is(s_axi_araddr, `OFS_CHANGE_FLAG)) begin
            rd_value[WIDTH-1:0] = change_flag_reg;
        end else if (addr_is(s_axi_araddr, `OFS_IRQ_CONTROL)) begin
            rd_value[`BIT_MASTER_ENABLE] = change_irq_master_enable;
            rd_value[`BIT_SUMMARY_FLAG]  = change_summary_flag;   // R09
            rd_value[`BIT_SLEEP]         = sleep_mode;
        end else if (addr_is(s_axi_araddr, `OFS_IRQ_STATUS)) begin
            rd_value[`EVT_WIDTH-1:0] = evt_status;
        end else if (addr_is(s_axi_araddr, `OFS_IRQ_MASK)) begin
            rd_value[`EVT_WIDTH-1:0] = evt_mask;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Accept address, return data, hold until rready
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `RESP_OKAY;
            rd_state      <= RD_IDLE;
        end else begin
            s_axi_arready <= 1'b0;
            case (rd_state)
                RD_IDLE: begin
                    if (s_axi_arvalid && !s_axi_arready) begin
                        s_axi_arready <= 1'b1;
                    end
                    if (rd_fire) begin
                        s_axi_rdata  <= rd_value;
                        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
                        s_axi_rvalid <= 1'b1;
                        rd_state     <= RD_DATA;
                    end
                end
                RD_DATA: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_state     <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= RD_IDLE;
                end
            endcase
        end
    end

endmodule : pin_change_interrupt

/* File: tb/pin_change_interrupt_asserts.sv */
// Port-level checker for the pin-change interrupt block.
// Assumes the params header on the include path and one clock domain.
`timescale 1ns/1ps
`include "pin_change_params.svh"
module pin_change_interrupt_asserts #(
    parameter int WIDTH      = 8,   // Port width
    parameter int ADDR_WIDTH = 12   // Bus address width
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  change_irq,
    input wire logic                  wake_request,
    input wire logic                  irq,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready
);
    // ==========================================================
    // One clock, reset disables every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Bus answers
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer kept after taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h018
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

    // ==========================================================
    // Interrupt outputs
    a_wake_needs_master: assert property (wake_request |-> change_irq)
        else $error("wake without change request");
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !change_irq && !wake_request && !irq) else $error("output active after reset");
    a_change_irq_fall: assert property ($fell(change_irq) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("request lost alone");

    // Main scenarios reached
    c_wake: cover property (wake_request);
    c_both_irqs: cover property (irq && change_irq);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule : pin_change_interrupt_asserts

bind pin_change_interrupt pin_change_interrupt_asserts #(
    .WIDTH(WIDTH), .ADDR_WIDTH(ADDR_WIDTH)
) u_asserts (
    .clk(clk), .sys_rst(sys_rst), .change_irq(change_irq), .wake_request(wake_request),
    .irq(irq), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* File: tb/pin_source.sv */
// Outside circuit on the monitored port pins.
// Assumes the block's clock; levels change just after a rising edge.
`timescale 1ns/1ps
module pin_source (
    input  wire logic       clk,
    output logic [7:0]      pins
);
    // Port idles low until first driven
    initial pins = 8'h00;

    // ==========================================================
    // Puts a level on the pins and holds it for a number of cycles
    task automatic drive(input logic [7:0] v, input int hold);
        @(posedge clk);
        pins <= v;
        repeat (hold) @(negedge clk);
    endtask : drive
endmodule : pin_source

/* File: tb/pin_change_interrupt_bench.sv */
// Self-checking bench for the pin-change interrupt block.
// Assumes design, pin model and checker are compiled before it.
`timescale 1ns/1ps
`include "pin_change_params.svh"
module pin_change_interrupt_bench;
    import pin_change_pkg::*;
    // ==========================================================
    // Signals and notes
    logic        clk, sys_rst, change_irq, wake_request, irq;
    logic [7:0]  pins, rise, fall, flags;   // Port, bench copy of enables and flags
    logic [11:0] awaddr, araddr;            // Bus addresses
    logic [31:0] wdata, rdata;              // Bus data
    logic [1:0]  bresp, rresp;              // Response codes
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [33:0] rd_q[$];                   // Expected response and read word
    logic [1:0]  wr_q[$];                   // Expected write response
    int          err_count = 0;             // Mismatches
    int          samples_checked = 0;       // Comparisons
    int          seed = 28010;              // Random seed

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Design and outside pin model
    pin_change_interrupt u_dut (.clk(clk), .sys_rst(sys_rst), .monitored_port(pins),
        .change_irq(change_irq), .wake_request(wake_request), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pin_source u_pins (.clk(clk), .pins(pins));

    // ==========================================================
    // Compare tasks, one per kind of result
    task automatic check_word(input string what, input logic [33:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word
    task automatic check_pin(input string what, input logic exp, got);
        check_word(what, {33'h0, exp}, {33'h0, got});
    endtask : check_pin

    // Pairs each bus answer with the oldest note
    always @(posedge clk) begin
        if (rvalid && rready) check_word("read", rd_q.pop_front(), {rresp, rdata});
        if (bvalid && bready) check_word("bresp", {32'h0, wr_q.pop_front()}, {32'h0, bresp});
    end

    // ==========================================================
    // Bus master: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp);
        bit ad = 1'b0, wd = 1'b0;
        @(posedge clk);
        wr_q.push_back(resp);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            ad = ad | awready;
            wd = wd | wready;
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'b1;                 // Late ready: answer must hold
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp);
        @(posedge clk);
        rd_q.push_back({resp, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b1;                 // Late ready: data must hold
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    // Moves the pins and notes the enabled edges this makes
    task automatic pin(input logic [7:0] v, input int hold);
        flags = flags | (rise & ~pins & v) | (fall & pins & ~v);
        u_pins.drive(v, hold);
    endtask : pin

    // Verdict and end of run
    task automatic report_and_stop();
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog against a hung handshake
    initial begin
        #500000;
        err_count++;
        report_and_stop();
    end

    // ==========================================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, rise, fall, flags} = 80'h0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, then one unmapped word
        for (int a = 0; a <= 24; a += 4) begin
            rd(12'(a), 8'h00, (a == 24) ? `RESP_SLVERR : `RESP_OKAY);
        end
        wr(12'h018, 8'hFF, `RESP_SLVERR);
        // Rise on 3:0, fall on 5:2, 7:6 ignored, master still off
        rise = 8'h0F;
        fall = 8'h3C;
        wr(`OFS_IRQ_MASK, 8'h01, `RESP_OKAY);
        wr(`OFS_RISE_ENABLE, rise, `RESP_OKAY);
        wr(`OFS_FALL_ENABLE, fall, `RESP_OKAY);
        pin(8'hFF, 2);
        repeat (5) @(negedge clk);
        check_pin("change_irq", 1'b0, change_irq);
        check_pin("irq", 1'b1, irq);
        rd(`OFS_CHANGE_FLAG, flags, `RESP_OKAY);
        pin(8'h00, 1);
        repeat (5) @(negedge clk);
        rd(`OFS_CHANGE_FLAG, flags, `RESP_OKAY);
        rd(`OFS_IRQ_CONTROL, 8'h02, `RESP_OKAY);
        wr(`OFS_IRQ_CONTROL, 8'h01, `RESP_OKAY);
        @(negedge clk);
        check_pin("change_irq", 1'b1, change_irq);
        rd(`OFS_IRQ_STATUS, 8'h01, `RESP_OKAY);
        repeat (2) @(negedge clk);
        check_pin("irq", 1'b0, irq);
        // Clear seen flags by masking: two first, then the rest
        wr(`OFS_CHANGE_FLAG, 8'hFC, `RESP_OKAY);
        rd(`OFS_CHANGE_FLAG, 8'h3C, `RESP_OKAY);
        wr(`OFS_CHANGE_FLAG, 8'hC3, `RESP_OKAY);
        repeat (2) @(negedge clk);
        check_pin("change_irq", 1'b0, change_irq);
        // A falling edge landing during the clearing write survives it
        pin(8'hFF, 2);
        repeat (5) @(negedge clk);
        flags = 8'h00;
        fork
            wr(`OFS_CHANGE_FLAG, 8'h00, `RESP_OKAY);
            pin(8'h00, 2);
        join
        repeat (5) @(negedge clk);
        rd(`OFS_CHANGE_FLAG, flags, `RESP_OKAY);
        wr(`OFS_CHANGE_FLAG, ~flags, `RESP_OKAY);
        flags = 8'h00;
        rd(`OFS_IRQ_STATUS, 8'h01, `RESP_OKAY);
        // Sleep with master on: an edge wakes and is already flagged
        wr(`OFS_IRQ_MASK, 8'h03, `RESP_OKAY);
        wr(`OFS_IRQ_CONTROL, 8'h05, `RESP_OKAY);
        pin(8'hFF, 2);
        for (int i = 0; i < 8 && wake_request !== 1'b1; i++) @(negedge clk);
        check_pin("wake_request", 1'b1, wake_request);
        rd(`OFS_CHANGE_FLAG, flags, `RESP_OKAY);
        rd(`OFS_IRQ_STATUS, 8'h03, `RESP_OKAY);
        rd(`OFS_IRQ_CONTROL, 8'h03, `RESP_OKAY);
        // Reset in mid-run with flags pending
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        {rise, fall, flags} = 24'h0;
        rd(`OFS_CHANGE_FLAG, 8'h00, `RESP_OKAY);
        rd(`OFS_RISE_ENABLE, 8'h00, `RESP_OKAY);
        // Random enables and short or long pin pulses
        for (int n = 0; n < 12; n++) begin
            rise = 8'($random(seed));
            fall = 8'($random(seed));
            wr(`OFS_RISE_ENABLE, rise, `RESP_OKAY);
            wr(`OFS_FALL_ENABLE, fall, `RESP_OKAY);
            repeat (4) pin(8'($random(seed)), 1 + ($random(seed) & 1));
            repeat (5) @(negedge clk);
            rd(`OFS_CHANGE_FLAG, flags, `RESP_OKAY);
            wr(`OFS_CHANGE_FLAG, ~flags, `RESP_OKAY);
            flags = 8'h00;
        end
        report_and_stop();
    end
endmodule : pin_change_interrupt_bench
